// ---- design/pcmh_pkg.sv ----
// constants for the pcm highway coding and framing block
package pcmh_pkg;
  // impedance scaling code
  localparam int SCALE_W = 5;
  localparam logic [4:0] SCALE_CUTOFF = 5'h00;
  localparam logic [4:0] SCALE_LOOP = 5'h10;
  localparam logic [4:0] SCALE_ZERO_GAIN = 5'h00;
  // a-law alternate bit inversion mask
  localparam logic [7:0] ABI_MASK = 8'h55;
  // signaling byte field positions
  localparam int SIG_HOOK_BIT = 7;
  localparam int SIG_DET_BIT = 6;
  localparam int SIG_FAIL_BIT = 2;
  // highway geometry
  localparam int SLOT_W = 7;
  localparam int CNT_W = 11;
  localparam int WORD_W = 16;
  localparam logic [10:0] LEN_ONE_SLOT = 11'h008;
  localparam logic [10:0] LEN_TWO_SLOT = 11'h010;
  localparam logic [1:0] FS_RUN_TWO = 2'h2;
  localparam logic [1:0] FS_RUN_MAX = 2'h3;
  // default coefficient set, gains in milli-dB
  localparam logic signed [15:0] DEF_TX_GAIN_MDB = 16'sh1770;
  localparam logic signed [15:0] DEF_RX_GAIN_MDB = -16'sh2318;
  localparam logic DEF_ATTEN_DISABLE = 1'b0;
  localparam logic DEF_AMP_LOSS = 1'b0;
  // coefficient ram, rx buffer and pin synchronisers
  localparam int COEF_AW = 4;
  localparam int COEF_DW = 8;
  localparam int BUF_W = 17;
  localparam int SYNC_N = 8;
endpackage

// ---- design/pcmh_highway_core.sv ----
// pcm highway coding, signaling, robbed-bit and scaling control
`timescale 1ns/10ps
// Notes on behaviour
// - scaling gain is sixteenth step times code minus 16
// - code zero cuts scaling feedback off
// - code 10000 gives unity full digital loopback
// - loopback ignores line input, output at reference
// - a-law or mu-law, a-law uses bit inversion
// - linear is 16-bit two slots, sign first
// - double clock halves the pcm data shift rate
// - halving only inside slot timing, pll unaffected
// - clock source select feeds pll from pcm clock
// - signaling adds byte after companded data byte
// - signaling byte holds hook, detector, clock fail
// - signaling bit 7 follows data bit 0 directly
// - signaling slot sent while channel inactive
// - robbed bit only mu-law receive, tx intact
// - robbed frame drops lsb, expander adds half
// - robbed frame needs two-cycle sync after other
// - sync sampled on falling clock, high-high-low
// - default set: fixed gains, cutoff scaling, etc
// - defaults from rom, reads see ram only
// - slots are msb-first bytes from sync slot 0
module pcmh_highway_core (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // highway pins
  input wire logic pclk_in,
  input wire logic mclk_in,
  input wire logic frame_sync_in,
  input wire logic pcm_rx_in,
  output logic pcm_tx_out,
  output logic pcm_tx_en_out,
  output logic pll_ref_out,
  // coding and framing configuration
  input wire logic companding_alaw_in,
  input wire logic linear_code_in,
  input wire logic double_bit_clock_en_in,
  input wire logic master_clock_source_sel_in,
  input wire logic highway_signaling_en_in,
  input wire logic robbed_bit_en_in,
  input wire logic channel_active_in,
  input wire logic [6:0] tx_slot_in,
  input wire logic [6:0] rx_slot_in,
  // scaling and coefficient configuration
  input wire logic [4:0] impedance_scale_code_in,
  input wire logic default_coef_sel_in,
  input wire logic attenuator_disable_in,
  input wire logic transmit_amp_in,
  input wire logic receive_amp_in,
  input wire logic signed [15:0] transmit_gain_mdb_in,
  input wire logic signed [15:0] receive_gain_mdb_in,
  // line status pins for the signaling byte
  input wire logic hook_detect_in,
  input wire logic second_detect_in,
  input wire logic muxed_hook_detect_in,
  input wire logic muxed_detect_sel_in,
  input wire logic clock_fail_flag_in,
  // transmit sample from the signal processor
  input wire logic [15:0] tx_sample_in,
  // receive stream to the signal processor
  output logic [15:0] rx_data_out,
  output logic rx_half_lsb_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic rx_overrun_out,
  output logic robbed_frame_out,
  // analog path control
  output logic signed [4:0] scale_gain_out,
  output logic scale_enable_out,
  output logic full_loopback_out,
  output logic line_in_ignore_out,
  output logic line_out_ref_out,
  output logic attenuator_disable_out,
  output logic transmit_amp_out,
  output logic receive_amp_out,
  output logic signed [15:0] transmit_gain_mdb_out,
  output logic signed [15:0] receive_gain_mdb_out,
  output logic coef_from_rom_out,
  // programmable coefficient ram port
  input wire logic coef_wr_en_in,
  input wire logic [3:0] coef_addr_in,
  input wire logic [7:0] coef_wr_data_in,
  output logic [7:0] coef_rd_data_out
);

  // alternate bit inversion, same on both directions
  function automatic logic [7:0] pcmh_abi(input logic [7:0] b,
                                          input logic alaw);
    pcmh_abi = alaw ? (b ^ pcmh_pkg::ABI_MASK) : b;
  endfunction

  logic [pcmh_pkg::SYNC_N-1:0] raw_w;
  logic [pcmh_pkg::SYNC_N-1:0] sync1_reg;
  logic [pcmh_pkg::SYNC_N-1:0] sync2_reg;
  assign raw_w = {clock_fail_flag_in, muxed_hook_detect_in,
                  second_detect_in, hook_detect_in, pcm_rx_in,
                  frame_sync_in, mclk_in, pclk_in};

  // two-flop synchronisers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < pcmh_pkg::SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_in)
      begin
        if (srst_in)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= raw_w[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic pclk_s, mclk_s, fs_s, rx_s, hook_s, det2_s, mdet_s, fail_s;
  assign {fail_s, mdet_s, det2_s, hook_s, rx_s, fs_s, mclk_s,
          pclk_s} = sync2_reg;

  // edge and frame timing state
  logic pclk_prev_reg, fs_prev_reg, div_reg, framed_reg;
  logic [10:0] cnt_reg;
  logic [1:0] fs_run_reg;
  logic prev_two_reg, robbed_reg;
  logic pclk_fall, frame_start, bit_tick;
  logic [10:0] cnt_next;

  assign pclk_fall = pclk_prev_reg & ~pclk_s;
  assign frame_start = pclk_fall & fs_s & ~fs_prev_reg;
  // halving lives here only, the pll reference is untouched
  assign bit_tick = pclk_fall & (~double_bit_clock_en_in | div_reg |
                                 frame_start);
  assign cnt_next = frame_start ? '0 :
                    (&cnt_reg ? cnt_reg : cnt_reg + 11'h001);

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pclk_prev_reg <= 1'b0;
      fs_prev_reg <= 1'b0;
      div_reg <= 1'b0;
      framed_reg <= 1'b0;
      cnt_reg <= '1;
    end
    else
    begin
      pclk_prev_reg <= pclk_s;
      if (pclk_fall)
      begin
        fs_prev_reg <= fs_s;
        div_reg <= frame_start ? 1'b0 : ~div_reg;
      end
      if (frame_start)
        framed_reg <= 1'b1;
      if (bit_tick)
        cnt_reg <= cnt_next;
    end
  end

  // sync length classification on every falling edge
  logic sync_ended, run_two;
  assign sync_ended = pclk_fall & ~fs_s & (fs_run_reg != 2'h0);
  assign run_two = (fs_run_reg == pcmh_pkg::FS_RUN_TWO);

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      fs_run_reg <= 2'h0;
      prev_two_reg <= 1'b0;
      robbed_reg <= 1'b0;
    end
    else if (pclk_fall)
    begin
      if (fs_s)
        fs_run_reg <= (fs_run_reg == pcmh_pkg::FS_RUN_MAX) ?
                      fs_run_reg : fs_run_reg + 2'h1;
      else
        fs_run_reg <= 2'h0;
      if (sync_ended)
      begin
        prev_two_reg <= run_two;
        robbed_reg <= robbed_bit_en_in & ~companding_alaw_in &
                      run_two & ~prev_two_reg;
      end
    end
  end
  assign robbed_frame_out = robbed_reg;

  // transmit word assembly
  logic loop_mode;
  logic [15:0] loop_word_reg;
  logic [7:0] comp_byte, sig_byte;
  logic [15:0] tx_word_w, tx_word_reg;
  logic [10:0] tx_len, tx_off;
  logic tx_in_win, tx_sig_part;

  assign comp_byte = loop_mode ? loop_word_reg[7:0] :
                     pcmh_abi(tx_sample_in[7:0],
                              companding_alaw_in);
  always_comb
  begin
    sig_byte = 8'h00;
    sig_byte[pcmh_pkg::SIG_HOOK_BIT] = hook_s;
    sig_byte[pcmh_pkg::SIG_DET_BIT] = muxed_detect_sel_in ?
                                       mdet_s : det2_s;
    sig_byte[pcmh_pkg::SIG_FAIL_BIT] = fail_s;
  end
  // linear has priority if software sets both modes
  assign tx_word_w = linear_code_in ?
                     (loop_mode ? loop_word_reg : tx_sample_in) :
                     {comp_byte, sig_byte};
  assign tx_len = (linear_code_in | highway_signaling_en_in) ?
                  pcmh_pkg::LEN_TWO_SLOT : pcmh_pkg::LEN_ONE_SLOT;
  assign tx_off = cnt_next - {1'b0, tx_slot_in, 3'h0};
  // the first start edge must open the window before framed is set
  assign tx_in_win = (framed_reg | frame_start) & (tx_off < tx_len);
  assign tx_sig_part = ~linear_code_in & highway_signaling_en_in &
                       tx_off[3];

  // one bit per tick, msb first, straight into the sig byte
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pcm_tx_out <= 1'b0;
      pcm_tx_en_out <= 1'b0;
      tx_word_reg <= '0;
    end
    else if (bit_tick)
    begin
      if (tx_off == 11'h000)
        tx_word_reg <= tx_word_w;
      pcm_tx_out <= (tx_off == 11'h000) ? tx_word_w[15] :
                    tx_word_reg[4'hf - tx_off[3:0]];
      pcm_tx_en_out <= tx_in_win & (channel_active_in |
                                    tx_sig_part);
    end
  end

  // receive shifting and word processing
  logic [15:0] rx_shift_reg, rx_full_w, rx_word_w;
  logic [10:0] rx_len, rx_off;
  logic [7:0] rx_code;
  logic rx_last, rx_robbed;

  assign rx_len = linear_code_in ? pcmh_pkg::LEN_TWO_SLOT :
                  pcmh_pkg::LEN_ONE_SLOT;
  assign rx_off = cnt_next - {1'b0, rx_slot_in, 3'h0};
  assign rx_last = bit_tick & framed_reg &
                   (rx_off == rx_len - 11'h001);
  assign rx_full_w = {rx_shift_reg[14:0], rx_s};
  assign rx_robbed = robbed_reg & ~linear_code_in;
  assign rx_code = pcmh_abi(rx_full_w[7:0], companding_alaw_in) &
                   {7'h7f, ~rx_robbed};
  assign rx_word_w = linear_code_in ? rx_full_w :
                     {8'h00, rx_code};

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rx_shift_reg <= '0;
      loop_word_reg <= '0;
    end
    else if (bit_tick)
    begin
      rx_shift_reg <= rx_full_w;
      if (rx_last)
        loop_word_reg <= rx_full_w;
    end
  end

  // two-entry buffer toward the signal processor
  logic [pcmh_pkg::BUF_W-1:0] buf_mem [2];
  logic wr_ptr_reg, rd_ptr_reg;
  logic [1:0] buf_cnt_reg;
  logic buf_full, buf_push, buf_pop;
  assign buf_full = buf_cnt_reg[1];
  assign buf_push = rx_last & ~buf_full;
  assign buf_pop = rx_valid_out & rx_ready_in;
  assign rx_valid_out = (buf_cnt_reg != 2'h0);
  assign {rx_half_lsb_out, rx_data_out} = buf_mem[rd_ptr_reg];

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
      rx_overrun_out <= 1'b0;
    end
    else
    begin
      if (buf_push)
      begin
        buf_mem[wr_ptr_reg] <= {rx_robbed, rx_word_w};
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (buf_pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} -
                     {1'b0, buf_pop};
      // the line cannot be stalled, so a full buffer drops
      rx_overrun_out <= rx_last & buf_full;
    end
  end

  // scaling decode and default coefficient selection
  logic [4:0] eff_code;
  logic code_cut, code_loop;
  assign eff_code = default_coef_sel_in ? pcmh_pkg::SCALE_CUTOFF :
                    impedance_scale_code_in;
  assign code_cut = (eff_code == pcmh_pkg::SCALE_CUTOFF);
  assign code_loop = (eff_code == pcmh_pkg::SCALE_LOOP);
  assign loop_mode = full_loopback_out;

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      scale_gain_out <= pcmh_pkg::SCALE_ZERO_GAIN;
      scale_enable_out <= 1'b0;
      full_loopback_out <= 1'b0;
      line_in_ignore_out <= 1'b0;
      line_out_ref_out <= 1'b0;
      pll_ref_out <= 1'b0;
    end
    else
    begin
      // code minus 16 is the code with its top bit flipped
      scale_gain_out <= (code_cut | code_loop) ?
                        pcmh_pkg::SCALE_ZERO_GAIN :
                        {~eff_code[4], eff_code[3:0]};
      scale_enable_out <= ~code_cut & ~code_loop;
      full_loopback_out <= code_loop;
      line_in_ignore_out <= code_loop;
      line_out_ref_out <= code_loop;
      pll_ref_out <= master_clock_source_sel_in ?
                     pclk_s : mclk_s;
    end
  end

  // default set comes from constants, never from the ram
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      attenuator_disable_out <= pcmh_pkg::DEF_ATTEN_DISABLE;
      transmit_amp_out <= pcmh_pkg::DEF_AMP_LOSS;
      receive_amp_out <= pcmh_pkg::DEF_AMP_LOSS;
      transmit_gain_mdb_out <= pcmh_pkg::DEF_TX_GAIN_MDB;
      receive_gain_mdb_out <= pcmh_pkg::DEF_RX_GAIN_MDB;
      coef_from_rom_out <= 1'b1;
    end
    else
    begin
      attenuator_disable_out <= default_coef_sel_in ?
        pcmh_pkg::DEF_ATTEN_DISABLE : attenuator_disable_in;
      transmit_amp_out <= default_coef_sel_in ?
        pcmh_pkg::DEF_AMP_LOSS : transmit_amp_in;
      receive_amp_out <= default_coef_sel_in ?
        pcmh_pkg::DEF_AMP_LOSS : receive_amp_in;
      transmit_gain_mdb_out <= default_coef_sel_in ?
        pcmh_pkg::DEF_TX_GAIN_MDB : transmit_gain_mdb_in;
      receive_gain_mdb_out <= default_coef_sel_in ?
        pcmh_pkg::DEF_RX_GAIN_MDB : receive_gain_mdb_in;
      coef_from_rom_out <= default_coef_sel_in;
    end
  end

  // programmable ram, unwritten words read back undefined
  logic [pcmh_pkg::COEF_DW-1:0] coef_ram [2**pcmh_pkg::COEF_AW];
  always_ff @(posedge clk_sys_in)
  begin
    if (coef_wr_en_in)
      coef_ram[coef_addr_in] <= coef_wr_data_in;
  end
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      coef_rd_data_out <= 8'h00;
    else
      coef_rd_data_out <= coef_ram[coef_addr_in];
  end

endmodule

// ---- sim/pcmh_highway_chk.sv ----
// concurrent checks on the pcm highway block ports
`timescale 1ns/10ps
module pcmh_highway_chk (
  // clock, reset and highway
  input wire logic clk_sys_in, srst_in, pclk_in, pcm_tx_out,
  // configuration
  input wire logic companding_alaw_in, robbed_bit_en_in,
  input wire logic default_coef_sel_in, receive_amp_in,
  input wire logic [4:0] impedance_scale_code_in,
  input wire logic signed [15:0] transmit_gain_mdb_in,
  // receive stream
  input wire logic [15:0] rx_data_out,
  input wire logic rx_half_lsb_out, rx_valid_out, robbed_frame_out,
  // analog and coefficient control
  input wire logic signed [4:0] scale_gain_out,
  input wire logic scale_enable_out, full_loopback_out,
  input wire logic line_in_ignore_out, line_out_ref_out,
  input wire logic attenuator_disable_out, transmit_amp_out,
  input wire logic receive_amp_out, coef_from_rom_out,
  input wire logic signed [15:0] transmit_gain_mdb_out,
  input wire logic signed [15:0] receive_gain_mdb_out
);
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  // code minus 16 is the same as flipping the top bit
  scale_gain_a: assert property (
    !default_coef_sel_in && impedance_scale_code_in != 5'h00
    && impedance_scale_code_in != 5'h10
    |=> scale_enable_out
    && scale_gain_out == $signed($past(impedance_scale_code_in) ^ 5'h10))
    else $error("scale gain");
  scale_cut_a: assert property (
    impedance_scale_code_in == 5'h00 |=> scale_gain_out == 5'sh00
    && !scale_enable_out && !full_loopback_out) else $error("cutoff");
  full_loop_a: assert property (
    !default_coef_sel_in && impedance_scale_code_in == 5'h10
    |=> full_loopback_out
    && line_in_ignore_out && line_out_ref_out && !scale_enable_out)
    else $error("loopback");
  def_coef_a: assert property (
    default_coef_sel_in |=> transmit_gain_mdb_out == 16'h1770
    && receive_gain_mdb_out == 16'hdce8 && !attenuator_disable_out
    && !transmit_amp_out && !receive_amp_out && coef_from_rom_out)
    else $error("default set");
  prog_coef_a: assert property (
    !default_coef_sel_in |=> !coef_from_rom_out
    && receive_amp_out == $past(receive_amp_in)
    && transmit_gain_mdb_out == $past(transmit_gain_mdb_in))
    else $error("programmed set");
  robbed_cond_a: assert property (
    $rose(robbed_frame_out) |-> $past(robbed_bit_en_in)
    && !$past(companding_alaw_in)) else $error("robbed cause");
  half_lsb_a: assert property (
    rx_valid_out && rx_half_lsb_out |-> rx_data_out[0] == 1'b0)
    else $error("half lsb");
  // pin fall needs sync stages, so the bit moves while pclk is low
  tx_tick_a: assert property (
    $changed(pcm_tx_out) |-> !$past(pclk_in) && !$past(pclk_in, 3))
    else $error("tx off tick");
  robbed_c: cover property ($rose(robbed_frame_out));
  half_c: cover property (rx_valid_out && rx_half_lsb_out);
  loop_c: cover property (full_loopback_out);
endmodule
bind pcmh_highway_core pcmh_highway_chk chk_i (.*);

// ---- sim/pcmh_framer_model.sv ----
// backplane framer model: bit clock, frame sync, receive data
`timescale 1ns/10ps
module pcmh_framer_model (
  // pacing clock and device output
  input wire logic clk_sys_in,
  input wire logic pcm_tx_out,
  input wire logic pcm_tx_en_out,
  // highway lines driven toward the device
  output logic pclk_in,
  output logic frame_sync_in,
  output logic pcm_rx_in
);
  logic [15:0] seen, seen_en;
  initial
  begin
    pclk_in = 1'b0;
    frame_sync_in = 1'b0;
    pcm_rx_in = 1'b0;
  end
  // one frame, rate 2 holds each bit two pclk periods; clock idles low
  task automatic frame(input int fs, nb, rt, input logic [15:0] w);
    for (int p = 0; p < nb * rt + 3; p++)
    begin
      repeat (6) @(negedge clk_sys_in);
      // device bit is settled well before the next rising edge
      if (p > 0 && (p - 1) % rt == 0 && (p - 1) / rt < nb)
      begin
        seen[nb - 1 - (p - 1) / rt] = pcm_tx_out;
        seen_en[nb - 1 - (p - 1) / rt] = pcm_tx_en_out;
      end
      pclk_in = 1'b1;
      frame_sync_in = (p < fs);
      // released line shows the inverse, not a stale copy
      if (p % rt == 0)
        pcm_rx_in = (p / rt < nb) ? w[nb - 1 - p / rt] : ~pcm_rx_in;
      repeat (6) @(negedge clk_sys_in);
      pclk_in = 1'b0;
    end
  endtask
endmodule

// ---- sim/pcmh_highway_core_tb.sv ----
// self-checking bench for the pcm highway coding block
`timescale 1ns/10ps
module pcmh_highway_core_tb;
  // design inputs, low at time zero except srst_in, channel_active_in, tx_sample_in and transmit_gain_mdb_in
  logic clk_sys_in, srst_in, pclk_in, frame_sync_in, pcm_rx_in;
  logic mclk_in = '0, companding_alaw_in = '0, linear_code_in = '0;
  logic double_bit_clock_en_in = '0, master_clock_source_sel_in = '0;
  logic highway_signaling_en_in = '0, robbed_bit_en_in = '0;
  logic channel_active_in = '1, default_coef_sel_in = '0;
  logic attenuator_disable_in = '0, transmit_amp_in = '0;
  logic receive_amp_in = '0, hook_detect_in = '0, second_detect_in = '0;
  logic muxed_hook_detect_in = '0, muxed_detect_sel_in = '0;
  logic clock_fail_flag_in = '0, rx_ready_in = '0, coef_wr_en_in = '0;
  logic [6:0] tx_slot_in = '0, rx_slot_in = '0;
  logic [4:0] impedance_scale_code_in = '0;
  logic signed [15:0] transmit_gain_mdb_in = 16'h0123;
  logic signed [15:0] receive_gain_mdb_in = '0;
  logic [15:0] tx_sample_in = 16'h00a7;
  logic [3:0] coef_addr_in = '0;
  logic [7:0] coef_wr_data_in = '0;
  // design outputs
  logic pcm_tx_out, pcm_tx_en_out, pll_ref_out, rx_half_lsb_out;
  logic rx_valid_out, rx_overrun_out, robbed_frame_out, scale_enable_out;
  logic full_loopback_out, line_in_ignore_out, line_out_ref_out;
  logic attenuator_disable_out, transmit_amp_out, receive_amp_out;
  logic coef_from_rom_out;
  logic [15:0] rx_data_out;
  logic [7:0] coef_rd_data_out;
  logic signed [4:0] scale_gain_out, g;
  logic signed [15:0] transmit_gain_mdb_out, receive_gain_mdb_out;
  int n_mismatch, check_count, cyc, n_ovr;
  pcmh_highway_core uut (.*);
  pcmh_framer_model fm (.*);
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // hang guard and overrun pulse count
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (rx_overrun_out === 1'b1)
      n_ovr <= n_ovr + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, s);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rst();
    srst_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    srst_in = 1'b0;
  endtask
  // pop one word; companded code comes back with inversion undone
  task automatic pop(input logic [15:0] e, input logic h);
    logic [15:0] m;
    int w = 0;
    m = linear_code_in ? 16'hffff : 16'h00ff;
    // an edge between pops, so ready never drops and rises at once
    @(negedge clk_sys_in);
    while (rx_valid_out !== 1'b1 && w < 100)
    begin
      @(negedge clk_sys_in);
      w++;
    end
    chk("rx_valid", 1, rx_valid_out);
    chk("rx_word", e & m, rx_data_out & m);
    chk("rx_half", h, rx_half_lsb_out);
    rx_ready_in = 1'b1;
    @(negedge clk_sys_in);
    rx_ready_in = 1'b0;
  endtask
  // one frame, then both directions compared
  task automatic hw(input int fs, nb, rt, input logic [15:0] r, t, e,
                    input logic h);
    logic [15:0] m;
    m = (nb == 8) ? 16'h00ff : 16'hffff;
    fm.frame(fs, nb, rt, r);
    chk("tx_word", t & m, fm.seen & m);
    chk("tx_en", m, fm.seen_en & m);
    pop(e, h);
  endtask
  initial
  begin
    rst();
    robbed_bit_en_in = 1'b1;
    hw(2, 8, 1, 16'h3d, 16'ha7, 16'h3c, 1);
    hw(2, 8, 1, 16'h3d, 16'ha7, 16'h3d, 0);
    hw(3, 8, 1, 16'h3d, 16'ha7, 16'h3d, 0);
    companding_alaw_in = 1'b1;
    hw(2, 8, 1, 16'h3d, 16'hf2, 16'h68, 0);
    {companding_alaw_in, double_bit_clock_en_in} = 2'h1;
    hw(1, 8, 2, 16'h5a, 16'ha7, 16'h5a, 0);
    {robbed_bit_en_in, double_bit_clock_en_in} = 2'h0;
    hw(2, 8, 1, 16'h3d, 16'ha7, 16'h3d, 0);
    {linear_code_in, tx_sample_in} = {1'b1, 16'h8123};
    hw(1, 16, 1, 16'hc0f1, 16'h8123, 16'hc0f1, 0);
    {linear_code_in, tx_sample_in} = {1'b0, 16'h00a7};
    // companded code kept while signaling is on
    highway_signaling_en_in = 1'b1;
    {hook_detect_in, muxed_hook_detect_in} = 2'h3;
    {muxed_detect_sel_in, clock_fail_flag_in} = 2'h3;
    hw(1, 16, 1, 16'h3c00, 16'ha7c4, 16'h3c, 0);
    {channel_active_in, muxed_detect_sel_in} = 2'h0;
    fm.frame(1, 16, 1, 16'h0);
    chk("sig_byte", 16'h84, fm.seen[7:0]);
    chk("sig_en", 16'h00ff, fm.seen_en);
    // mid-run reset also empties the buffer; reader stalls
    rst();
    {highway_signaling_en_in, channel_active_in} = 2'h1;
    for (int i = 1; i < 4; i++)
      fm.frame(1, 8, 1, 16'(i * 17));
    chk("overrun", 1, n_ovr);
    pop(16'h11, 0);
    pop(16'h22, 0);
    chk("rx_empty", 0, rx_valid_out);
    // slot 1 puts both directions one byte after the sync
    {tx_slot_in, rx_slot_in} = {7'h01, 7'h01};
    fm.frame(1, 16, 1, 16'h005a);
    chk("slot_tx", 16'ha7, fm.seen[7:0]);
    chk("slot_en", 16'h00ff, fm.seen_en);
    pop(16'h5a, 0);
    {tx_slot_in, rx_slot_in} = 14'h0;
    // loopback sends the word taken in the frame before
    impedance_scale_code_in = 5'h10;
    hw(1, 8, 1, 16'h96, 16'h5a, 16'h96, 0);
    hw(1, 8, 1, 16'h3d, 16'h96, 16'h3d, 0);
    mclk_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    chk("pll_mclk", 1, pll_ref_out);
    master_clock_source_sel_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    chk("pll_pclk", 0, pll_ref_out);
    for (int c = 0; c < 32; c++)
    begin
      impedance_scale_code_in = 5'(c);
      @(negedge clk_sys_in);
      g = (c == 0 || c == 16) ? 5'sh0 : 5'(c - 16);
      chk("scale", g, scale_gain_out);
      chk("loop", c == 16, full_loopback_out);
    end
    default_coef_sel_in = 1'b1;
    // taps are written by software, never left at a zero default
    {coef_wr_en_in, coef_addr_in, coef_wr_data_in} = 13'h135a;
    @(negedge clk_sys_in);
    coef_wr_en_in = 1'b0;
    chk("tx_gain", 16'h1770, transmit_gain_mdb_out);
    chk("rx_gain", 16'hdce8, receive_gain_mdb_out);
    repeat (2) @(negedge clk_sys_in);
    chk("coef_rd", 16'h5a, coef_rd_data_out);
    default_coef_sel_in = 1'b0;
    @(negedge clk_sys_in);
    chk("tx_gain", 16'h0123, transmit_gain_mdb_out);
    stop_test();
  end
endmodule
